//--- common/pmcrc_defs.vh
// Constants for the program memory checksum register set and its debug link.
// Included by the top-level design file and the testbench; holds definitions only.
`ifndef PMCRC_DEFS_VH
`define PMCRC_DEFS_VH

// Debug-link register addresses
`define PMCRC_ADDR_BYTE_ZERO  8'hA9
`define PMCRC_ADDR_BYTE_ONE   8'hAA
`define PMCRC_ADDR_BYTE_TWO   8'hAB
`define PMCRC_ADDR_BYTE_THREE 8'hAC

// Reset value of every result byte
`define PMCRC_BYTE_RESET      8'h00

// Whole-memory checksum start address and block checksum geometry
`define PMCRC_FULL_START      16'h0000
`define PMCRC_BLOCK_LOW_BYTE  8'h00
`define PMCRC_BLOCK_BYTES     17'h00100

// Default program memory size in bytes and checksum seeds and polynomials
`define PMCRC_MEM_BYTES       17'h04000
`define PMCRC_POLY32          32'h04C11DB7
`define PMCRC_SEED32          32'hFFFFFFFF
`define PMCRC_POLY16          16'h1021
`define PMCRC_SEED16          16'hFFFF

// Link frame layout: start bit, direction bit, 8 address bits, 8 data bits
`define PMCRC_FIELD_BITS      4'h8

`endif

//--- rtl/pmcrc_sync.v
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to ref_clk; only the second flop is read.
`timescale 1ns/1ps

module pmcrc_sync #(
   parameter [0:0] RESET_LEVEL = 1'b0
) (
   ref_clk,
   rst,
   pin_in,
   level_q
);
   input  wire ref_clk;
   input  wire rst;
   input  wire pin_in;
   output reg  level_q;

   reg         meta_q;

   // First flop feeds only the second one; reset to the pin's idle level so no
   // false edge or false level follows reset
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_q  <= RESET_LEVEL;
         level_q <= RESET_LEVEL;
      end else begin
         meta_q  <= pin_in;
         level_q <= meta_q;
      end
   end
endmodule // pmcrc_sync

//--- rtl/pmcrc_top.v
// Program memory checksum registers reached over the two-wire debug link.
// Assumes a byte-wide program memory read port answering one cycle after a read strobe,
// and a halt request from the debug controller on ref_clk.
`timescale 1ns/1ps
`include "pmcrc_defs.vh"

module pmcrc_top #(
   parameter        ADDR_W    = 16,
   parameter [16:0] MEM_BYTES = `PMCRC_MEM_BYTES
) (
   ref_clk,
   rst,
   halt_request,
   debug_link_clock_pin,
   debug_link_data_pin_in,
   debug_link_data_pin_out,
   debug_link_data_pin_oe,
   core_stall,
   pin_reset_request,
   checksum_busy,
   mem_addr,
   mem_rd,
   mem_rdata
);
   input  wire              ref_clk;
   input  wire              rst;
   input  wire              halt_request;
   input  wire              debug_link_clock_pin;
   input  wire              debug_link_data_pin_in;
   output reg               debug_link_data_pin_out;
   output reg               debug_link_data_pin_oe;
   output reg               core_stall;
   output reg               pin_reset_request;
   output reg               checksum_busy;
   output reg  [ADDR_W-1:0] mem_addr;
   output reg               mem_rd;
   input  wire [7:0]        mem_rdata;

   // Link frame states
   localparam [2:0] L_IDLE = 3'd0;
   localparam [2:0] L_DIR  = 3'd1;
   localparam [2:0] L_ADDR = 3'd2;
   localparam [2:0] L_WDAT = 3'd3;
   localparam [2:0] L_RDAT = 3'd4;
   // Checksum engine states
   localparam [1:0] C_IDLE  = 2'd0;
   localparam [1:0] C_ISSUE = 2'd1;
   localparam [1:0] C_WAIT  = 2'd2;
   localparam [1:0] C_ACC   = 2'd3;

   wire        clk_lvl;
   wire        dat_lvl;
   reg         clk_prev_q;
   reg  [2:0]  lst_q;
   reg  [3:0]  bit_cnt_q;
   reg         dir_write_q;
   reg  [7:0]  addr_sh_q;
   reg  [7:0]  dat_sh_q;
   reg  [7:0]  rd_sh_q;
   reg  [7:0]  byte0_q;
   reg  [7:0]  byte1_q;
   reg  [7:0]  byte2_q;
   reg  [7:0]  byte3_q;
   reg  [1:0]  cst_q;
   reg         wide_q;
   reg  [16:0] left_q;
   reg  [31:0] crc_q;
   reg  [7:0]  rd_mux;
   reg         wr_pulse;
   reg  [7:0]  wr_addr;
   reg  [7:0]  wr_data;
   wire        link_rise;

   // Both link pins go through two flops; the clock pin idles high as a released reset
   pmcrc_sync #(.RESET_LEVEL(1'b1)) u_sync_clk (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin_in  (debug_link_clock_pin),
      .level_q (clk_lvl)
   );
   pmcrc_sync u_sync_dat (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin_in  (debug_link_data_pin_in),
      .level_q (dat_lvl)
   );

   assign link_rise = core_stall && clk_lvl && !clk_prev_q;

   // MSB-first checksum of one byte, non-reflected
   function [31:0] crc32_byte;
      input [31:0] c;
      input [7:0]  d;
      integer      i;
      reg   [31:0] r;
      begin
         r = c;
         for (i = 7; i >= 0; i = i - 1)
            r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ `PMCRC_POLY32) : {r[30:0], 1'b0};
         crc32_byte = r;
      end
   endfunction

   function [15:0] crc16_byte;
      input [15:0] c;
      input [7:0]  d;
      integer      i;
      reg   [15:0] r;
      begin
         r = c;
         for (i = 7; i >= 0; i = i - 1)
            r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `PMCRC_POLY16) : {r[14:0], 1'b0};
         crc16_byte = r;
      end
   endfunction

   // Read data for the addressed result byte; unmapped addresses read zero
   always @* begin
      case (addr_sh_q)
         `PMCRC_ADDR_BYTE_ZERO:  rd_mux = byte0_q;
         `PMCRC_ADDR_BYTE_ONE:   rd_mux = byte1_q;
         `PMCRC_ADDR_BYTE_TWO:   rd_mux = byte2_q;
         `PMCRC_ADDR_BYTE_THREE: rd_mux = byte3_q;
         default:                rd_mux = 8'h00;
      endcase
   end

   // Halt gating of the shared pins; outside halt the clock pin is the active-low reset
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         core_stall        <= 1'b0;
         pin_reset_request <= 1'b0;
         clk_prev_q        <= 1'b1;
      end else begin
         core_stall        <= halt_request;
         pin_reset_request <= !halt_request && !clk_lvl;
         clk_prev_q        <= clk_lvl;
      end
   end

   // Link framing: start bit 1, direction (1 = write), address, then data
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lst_q                   <= L_IDLE;
         bit_cnt_q               <= 4'h0;
         dir_write_q             <= 1'b0;
         addr_sh_q               <= 8'h00;
         dat_sh_q                <= 8'h00;
         rd_sh_q                 <= 8'h00;
         debug_link_data_pin_out <= 1'b0;
         debug_link_data_pin_oe  <= 1'b0;
         wr_pulse                <= 1'b0;
         wr_addr                 <= 8'h00;
         wr_data                 <= 8'h00;
      end else begin
         wr_pulse <= 1'b0;
         if (!core_stall) begin
            // Leaving halt abandons any frame and frees the data pin
            lst_q                  <= L_IDLE;
            debug_link_data_pin_oe <= 1'b0;
         end else if (link_rise) begin
            case (lst_q)
               L_IDLE: begin
                  if (dat_lvl)
                     lst_q <= L_DIR;
               end
               L_DIR: begin
                  dir_write_q <= dat_lvl;
                  bit_cnt_q   <= 4'h0;
                  lst_q       <= L_ADDR;
               end
               L_ADDR: begin
                  addr_sh_q <= {addr_sh_q[6:0], dat_lvl};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == `PMCRC_FIELD_BITS - 4'h1) begin
                     bit_cnt_q <= 4'h0;
                     lst_q     <= dir_write_q ? L_WDAT : L_RDAT;
                  end
               end
               L_WDAT: begin
                  dat_sh_q  <= {dat_sh_q[6:0], dat_lvl};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == `PMCRC_FIELD_BITS - 4'h1) begin
                     wr_pulse <= 1'b1;
                     wr_addr  <= addr_sh_q;
                     wr_data  <= {dat_sh_q[6:0], dat_lvl};
                     lst_q    <= L_IDLE;
                  end
               end
               L_RDAT: begin
                  // First edge loads the byte and drives bit 7; the next seven edges shift, the ninth releases the pin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == 4'h0) begin
                     rd_sh_q                 <= {rd_mux[6:0], 1'b0};
                     debug_link_data_pin_out <= rd_mux[7];
                     debug_link_data_pin_oe  <= 1'b1;
                  end else if (bit_cnt_q == `PMCRC_FIELD_BITS) begin
                     debug_link_data_pin_oe <= 1'b0;
                     lst_q                  <= L_IDLE;
                  end else begin
                     rd_sh_q                 <= {rd_sh_q[6:0], 1'b0};
                     debug_link_data_pin_out <= rd_sh_q[7];
                  end
               end
               default: lst_q <= L_IDLE;
            endcase
         end
      end
   end

   // Register writes and the checksum engine; writes are ignored while busy so a
   // running checksum cannot be corrupted halfway
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         byte0_q       <= `PMCRC_BYTE_RESET;
         byte1_q       <= `PMCRC_BYTE_RESET;
         byte2_q       <= `PMCRC_BYTE_RESET;
         byte3_q       <= `PMCRC_BYTE_RESET;
         cst_q         <= C_IDLE;
         wide_q        <= 1'b0;
         left_q        <= 17'h00000;
         crc_q         <= 32'h00000000;
         mem_addr      <= {ADDR_W{1'b0}};
         mem_rd        <= 1'b0;
         checksum_busy <= 1'b0;
      end else begin
         case (cst_q)
            C_IDLE: begin
               mem_rd <= 1'b0;
               if (wr_pulse) begin
                  case (wr_addr)
                     `PMCRC_ADDR_BYTE_ZERO: begin
                        byte0_q       <= wr_data;
                        wide_q        <= 1'b0;
                        crc_q         <= {16'h0000, `PMCRC_SEED16};
                        mem_addr      <= {wr_data, `PMCRC_BLOCK_LOW_BYTE};
                        left_q        <= `PMCRC_BLOCK_BYTES;
                        checksum_busy <= 1'b1;
                        cst_q         <= C_ISSUE;
                     end
                     `PMCRC_ADDR_BYTE_ONE: begin
                        byte1_q       <= wr_data;
                        wide_q        <= 1'b1;
                        crc_q         <= `PMCRC_SEED32;
                        mem_addr      <= `PMCRC_FULL_START;
                        left_q        <= MEM_BYTES;
                        checksum_busy <= 1'b1;
                        cst_q         <= C_ISSUE;
                     end
                     `PMCRC_ADDR_BYTE_TWO:   byte2_q <= wr_data;
                     `PMCRC_ADDR_BYTE_THREE: byte3_q <= wr_data;
                     default: ;
                  endcase
               end
            end
            C_ISSUE: begin
               mem_rd <= 1'b1;
               cst_q  <= C_WAIT;
            end
            C_WAIT: begin
               mem_rd <= 1'b0;
               cst_q  <= C_ACC;
            end
            C_ACC: begin
               left_q   <= left_q - 17'h00001;
               mem_addr <= mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
               if (wide_q)
                  crc_q <= crc32_byte(crc_q, mem_rdata);
               else
                  crc_q <= {16'h0000, crc16_byte(crc_q[15:0], mem_rdata)};
               if (left_q == 17'h00001) begin
                  checksum_busy <= 1'b0;
                  cst_q         <= C_IDLE;
                  if (wide_q) begin
                     {byte3_q, byte2_q, byte1_q, byte0_q} <= crc32_byte(crc_q, mem_rdata);
                  end else begin
                     {byte1_q, byte0_q} <= crc16_byte(crc_q[15:0], mem_rdata);
                  end
               end else begin
                  cst_q <= C_ISSUE;
               end
            end
            default: cst_q <= C_IDLE;
         endcase
      end
   end
endmodule // pmcrc_top

//--- verification/pmcrc_adapter.sv
// Debug adapter model: drives the link clock and data pin, frames one access.
// Assumes the device resolves the data pin from its enable; no pull on the line.
`timescale 1ns/1ps
module pmcrc_adapter (
   ref_clk,
   dev_out,
   dev_oe,
   clk_pin,
   data_pin
);
   input  wire ref_clk;
   input  wire dev_out;
   input  wire dev_oe;
   output reg  clk_pin;
   output wire data_pin;
   reg         drv_q;
   reg         val_q;
   reg         tog_q;
   // Clock pin idles high so the device sees no reset until the bench lowers it outside halt; it is only an input there
   initial begin
      clk_pin = 1'b1;
      drv_q = 1'b0;
      val_q = 1'b0;
      tog_q = 1'b0;
   end
   // A released line shows a moving value, so a stale bit cannot pass
   always @(posedge ref_clk) tog_q <= ~tog_q;
   assign data_pin = dev_oe ? dev_out : (drv_q ? val_q : tog_q);
   task tick(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
         #2;
      end
   endtask
   // Only this model drives the clock pin, also when the bench wants a reset level
   task set_clk(input v);
      clk_pin = v;
   endtask
   // One clock period; the line is sampled at the end of the low phase
   task pulse(output s);
      begin
         clk_pin = 1'b0;
         tick(6);
         s = data_pin;
         clk_pin = 1'b1;
         tick(6);
      end
   endtask
   // Driven bit held steady across its whole clock period
   task put(input v);
      reg s;
      begin
         drv_q = 1'b1;
         val_q = v;
         pulse(s);
      end
   endtask
   task frame(input wr, input [7:0] a, input [7:0] d, output [7:0] q);
      integer i;
      reg     s;
      begin
         q = 8'h00;
         put(1'b1);
         put(wr);
         for (i = 7; i >= 0; i = i - 1) put(a[i]);
         if (wr) for (i = 7; i >= 0; i = i - 1) put(d[i]);
         else begin
            drv_q = 1'b0;
            pulse(s);
            for (i = 7; i >= 0; i = i - 1) pulse(q[i]);
         end
         drv_q = 1'b0;
         tick(6);
      end
   endtask
endmodule // pmcrc_adapter

//--- verification/pmcrc_asserts.sv
// Checker for the checksum register set: stall, pin sharing and memory scan.
// Assumes it is bound to pmcrc_top and sees only that module's ports.
`timescale 1ns/1ps
module pmcrc_asserts #(
   parameter        ADDR_W    = 16,
   parameter [16:0] MEM_BYTES = 17'h04000
) (
   input wire              ref_clk,
   input wire              rst,
   input wire              halt_request,
   input wire              debug_link_clock_pin,
   input wire              debug_link_data_pin_in,
   input wire              debug_link_data_pin_out,
   input wire              debug_link_data_pin_oe,
   input wire              core_stall,
   input wire              pin_reset_request,
   input wire              checksum_busy,
   input wire [ADDR_W-1:0] mem_addr,
   input wire              mem_rd,
   input wire [7:0]        mem_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Halt stalls the core one cycle later and lets go just as fast
   stall_on_a: assert property ($rose(halt_request) |=> core_stall)
      else $error("stall missed halt");
   stall_off_a: assert property (!halt_request |=> !core_stall)
      else $error("stall without halt");
   // Data pin and reset pin belong to the link only while halted
   pin_idle_a: assert property (!core_stall && !$past(core_stall) |-> !debug_link_data_pin_oe)
      else $error("data pin driven outside halt");
   drive_halt_a: assert property ($rose(debug_link_data_pin_oe) |-> core_stall)
      else $error("data pin taken without halt");
   no_reset_a: assert property (core_stall && $past(core_stall) |-> !pin_reset_request)
      else $error("reset raised while halted");
   pin_reset_a: assert property ((!halt_request && !debug_link_clock_pin) [*4] |-> pin_reset_request)
      else $error("low pin gave no reset");
   // Every scan starts on a block boundary, from address zero for the whole memory
   start_low_a: assert property ($rose(checksum_busy) |-> mem_addr[7:0] == 8'h00)
      else $error("scan start not aligned");
   rd_pulse_a: assert property (mem_rd |=> !mem_rd)
      else $error("read strobe too long");
   rd_busy_a: assert property (mem_rd |-> checksum_busy)
      else $error("read outside a scan");
   // Address holds while data returns, then steps by one
   addr_hold_a: assert property (mem_rd |=> $stable(mem_addr))
      else $error("address moved under read");
   addr_step_a: assert property (checksum_busy && $past(checksum_busy) && $changed(mem_addr)
      |-> mem_addr == $past(mem_addr) + 1'b1)
      else $error("address skipped");
   cover property ($fell(checksum_busy));
   cover property ($rose(debug_link_data_pin_oe) && debug_link_data_pin_out);
   cover property ($rose(pin_reset_request));
   cover property (core_stall && !debug_link_data_pin_oe && debug_link_data_pin_in);
   cover property (mem_rd ##1 mem_rdata != 8'h00);
endmodule // pmcrc_asserts

bind pmcrc_top pmcrc_asserts #(.ADDR_W(ADDR_W), .MEM_BYTES(MEM_BYTES)) chk (
   .ref_clk(ref_clk), .rst(rst), .halt_request(halt_request),
   .debug_link_clock_pin(debug_link_clock_pin), .debug_link_data_pin_in(debug_link_data_pin_in),
   .debug_link_data_pin_out(debug_link_data_pin_out),
   .debug_link_data_pin_oe(debug_link_data_pin_oe), .core_stall(core_stall),
   .pin_reset_request(pin_reset_request), .checksum_busy(checksum_busy),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

//--- verification/test_debug_port_program_memory_checksum.sv
// Self-checking bench for the checksum registers over the debug link.
// Assumes pmcrc_top, the adapter model and a patterned memory in this module.
`timescale 1ns/1ps
`include "pmcrc_defs.vh"
module test_debug_port_program_memory_checksum;
   localparam [16:0] MEMB = 17'h00200;
   reg         ref_clk;
   reg         rst;
   reg         halt_request;
   reg  [7:0]  mem_rdata;
   wire        clk_pin, data_pin, d_out, d_oe, core_stall, pin_rst, busy, mem_rd;
   wire [15:0] mem_addr;
   integer     mismatches, n_tests, cyc, i;
   reg  [7:0]  q;
   reg  [31:0] e;
   pmcrc_top #(.MEM_BYTES(MEMB)) dut (.ref_clk(ref_clk), .rst(rst),
      .halt_request(halt_request), .debug_link_clock_pin(clk_pin),
      .debug_link_data_pin_in(data_pin), .debug_link_data_pin_out(d_out),
      .debug_link_data_pin_oe(d_oe), .core_stall(core_stall), .pin_reset_request(pin_rst),
      .checksum_busy(busy), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
   pmcrc_adapter ad (.ref_clk(ref_clk), .dev_out(d_out), .dev_oe(d_oe),
      .clk_pin(clk_pin), .data_pin(data_pin));
   function [7:0] pat(input [15:0] a);
      pat = a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   // Memory answers the cycle after a strobe, else shows a moving value
   always @(posedge ref_clk) mem_rdata <= mem_rd ? pat(mem_addr) : ~mem_rdata;
   // Reference checksum, MSB first, no final inversion
   function [31:0] crc_of(input w, input [15:0] st, input [16:0] n);
      reg [31:0] c;
      reg [7:0]  d;
      integer    k, b;
      begin
         c = w ? `PMCRC_SEED32 : {16'h0000, `PMCRC_SEED16};
         for (k = 0; k < n; k = k + 1) begin
            d = pat(st + k[15:0]);
            for (b = 7; b >= 0; b = b - 1) begin
               if (w) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? `PMCRC_POLY32 : 32'h0);
               else c = {16'h0000, c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 32'h1021 : 32'h0);
            end
         end
         crc_of = c;
      end
   endfunction
   task check(input [31:0] s, input [31:0] x);
      begin
         n_tests = n_tests + 1;
         if (s !== x) begin
            mismatches = mismatches + 1;
            $display("[ERR] t=%0t seen %h expected %h", $time, s, x);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      ad.frame(1'b1, a, d, q);
   endtask
   task rd(input [7:0] a, input [7:0] x);
      begin
         ad.frame(1'b0, a, 8'h00, q);
         check({24'h0, q}, {24'h0, x});
      end
   endtask
   // Results are read only after the scan ends; a bounded wait
   task wait_idle;
      integer k;
      begin
         k = 0;
         while (busy !== 1'b0 && k < 4000) begin
            ad.tick(1);
            k = k + 1;
         end
         check(k < 4000, 1'b1);
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Hang guard, well above the expected run length
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end
   initial begin
      mismatches = 0;
      n_tests = 0;
      cyc = 0;
      rst = 1'b1;
      halt_request = 1'b0;
      mem_rdata = 8'h00;
      repeat (8) @(posedge ref_clk);
      #2 rst = 1'b0;
      ad.tick(2);
      check(pin_rst, 1'b0);
      halt_request = 1'b1;
      ad.tick(3);
      check(core_stall, 1'b1);
      for (i = 0; i < 4; i = i + 1) rd(8'hA9 + i[7:0], 8'h00);
      $display("test reset_values done");
      wr(8'hAB, 8'h3C);
      wr(8'hAC, 8'hC3);
      wr(8'h55, 8'hFF);
      rd(8'hAB, 8'h3C);
      rd(8'hAC, 8'hC3);
      rd(8'h55, 8'h00);
      $display("test store_unmapped done");
      wr(8'hA9, 8'h01);
      check(busy, 1'b1);
      wr(8'hAB, 8'h99);
      wait_idle;
      e = crc_of(1'b0, 16'h0100, 17'h00100);
      rd(8'hA9, e[7:0]);
      rd(8'hAA, e[15:8]);
      rd(8'hAB, 8'h3C);
      $display("test block_checksum done");
      wr(8'hAA, 8'h00);
      check(busy, 1'b1);
      wr(8'hAC, 8'h77);
      wait_idle;
      e = crc_of(1'b1, `PMCRC_FULL_START, MEMB);
      for (i = 0; i < 4; i = i + 1) rd(8'hA9 + i[7:0], e[8*i +: 8]);
      $display("test full_checksum done");
      rst = 1'b1;
      ad.tick(2);
      rst = 1'b0;
      ad.tick(2);
      check(pin_rst, 1'b0);
      check(core_stall, 1'b1);
      rd(8'hAC, 8'h00);
      rd(8'hAA, 8'h00);
      $display("test mid_reset done");
      halt_request = 1'b0;
      ad.tick(3);
      check(core_stall, 1'b0);
      ad.set_clk(1'b0);
      ad.tick(6);
      check(pin_rst, 1'b1);
      ad.set_clk(1'b1);
      ad.tick(6);
      check(pin_rst, 1'b0);
      $display("test pin_sharing done");
      give_verdict;
   end
endmodule // test_debug_port_program_memory_checksum
